// ===== verilog/tsl_top.sv
// talkback signaling logic: dim, cut, lamps and broadcast mode
// What this block does
// - desk talk, or producer talk in the control room, dims monitors, prelisten
// - return one talk dims room a, in-studio
// - return two talk dims room b, in-studio
// - fader start or broadcast cuts room a
// - fader start or broadcast cuts room b
// - external one cut with room a, in-studio
// - external two cut with room b, in-studio
// - room a signal one lamp ORs in/out
// - room a signal two lamp ORs in/out
// - room a warning on cut or manual
// - room a talk lamp on console/return talk
// - room b signal one lamp ORs in/out
// - room b signal two lamp ORs in/out
// - room b warning on cut or manual
// - room b talk lamp on console/return talk
// - broadcast mode from key or selected input
// - warning key toggles manual request, shows state
// - broadcast mode blocks hazardous functions
// - studio talk feeds both rooms together
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module tsl_top
  import tsl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic i_desk_talk,
  input wire logic i_producer_talk,
  input wire logic i_producer_in_control_room,
  input wire logic i_studio_talk_key,
  input wire logic i_console_talk_to_room_a,
  input wire logic i_console_talk_to_room_b,
  input wire logic i_return_one_talk_to_control_room,
  input wire logic i_return_two_talk_to_control_room,
  input wire logic i_return_path_one_in_room,
  input wire logic i_return_path_two_in_room,
  input wire logic i_fader_start_room_a,
  input wire logic i_fader_start_room_b,
  input wire logic i_room_a_signal_one_out,
  input wire logic i_room_a_signal_two_out,
  input wire logic i_room_b_signal_one_out,
  input wire logic i_room_b_signal_two_out,
  input wire logic i_room_a_signal_one_in,
  input wire logic i_room_a_signal_two_in,
  input wire logic i_room_b_signal_one_in,
  input wire logic i_room_b_signal_two_in,
  input wire logic [GPI_W-1:0] i_gpi,
  input wire logic [ROOMS-1:0] i_warning_lamp_manual_key,
  input wire logic i_solo_in_place_req,
  input wire logic i_talk_to_masters_req,
  output logic o_dim_control_room,
  output logic o_dim_prelisten_feed,
  output logic o_dim_room_a,
  output logic o_dim_room_b,
  output logic o_cut_room_a,
  output logic o_cut_room_b,
  output logic o_cut_external_path_one,
  output logic o_cut_external_path_two,
  output logic o_room_a_signal_one_lamp,
  output logic o_room_a_signal_two_lamp,
  output logic o_room_b_signal_one_lamp,
  output logic o_room_b_signal_two_lamp,
  output logic o_room_a_warning_lamp,
  output logic o_room_b_warning_lamp,
  output logic o_room_a_talk_lamp,
  output logic o_room_b_talk_lamp,
  output logic [ROOMS-1:0] o_warning_key_lamp,
  output logic o_broadcast_mode,
  output logic o_solo_in_place_grant,
  output logic o_talk_to_masters_grant
);
  logic [SYNC_W-1:0] pins_sync;
  logic [GPI_W-1:0] gpi_sync;
  logic [SIG_IN_W-1:0] sig_in_sync;
  logic [DATA_W-1:0] ctrl_reg;
  logic [ROOMS-1:0] manual_reg;
  logic [ROOMS-1:0] manual_next;
  logic [ROOMS-1:0] warn_wr_toggle;
  logic broadcast_mode_reg;
  logic broadcast_mode_next;
  logic dim_monitor_reg;
  logic solo_grant_reg;
  logic masters_grant_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] status_word;
  logic talk_room_a;
  logic talk_room_b;
  logic any_desk_talk;
  logic [1:0] gpi_select;

  tsl_room_if room_bus[ROOMS] ();

  // optocoupler pins pass two flip-flops before use
  tsl_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async({i_room_b_signal_two_in, i_room_b_signal_one_in,
      i_room_a_signal_two_in, i_room_a_signal_one_in, i_gpi}),
    .o_sync(pins_sync)
  );
  assign gpi_sync = pins_sync[GPI_W-1:0];
  assign sig_in_sync = pins_sync[SYNC_W-1:GPI_W];

  // studio talk key reaches both rooms at once
  assign talk_room_a = i_console_talk_to_room_a | i_studio_talk_key;
  assign talk_room_b = i_console_talk_to_room_b | i_studio_talk_key;
  assign any_desk_talk = i_desk_talk | talk_room_a | talk_room_b;

  // per room inputs
  assign room_bus[0].ret_talk = i_return_one_talk_to_control_room;
  assign room_bus[0].ret_in_studio = i_return_path_one_in_room;
  assign room_bus[0].fader_start = i_fader_start_room_a;
  assign room_bus[0].console_talk = talk_room_a;
  assign room_bus[0].sig_out = {i_room_a_signal_two_out,
    i_room_a_signal_one_out};
  assign room_bus[0].sig_in = sig_in_sync[1:0];
  assign room_bus[1].ret_talk = i_return_two_talk_to_control_room;
  assign room_bus[1].ret_in_studio = i_return_path_two_in_room;
  assign room_bus[1].fader_start = i_fader_start_room_b;
  assign room_bus[1].console_talk = talk_room_b;
  assign room_bus[1].sig_out = {i_room_b_signal_two_out,
    i_room_b_signal_one_out};
  assign room_bus[1].sig_in = sig_in_sync[3:2];

  // one signaling slice per room, broadcast state per assignment bit
  for (genvar r = 0; r < ROOMS; r++) begin : g_room
    assign room_bus[r].onair = broadcast_mode_reg
      & ctrl_reg[CTRL_ASSIGN_LSB + r];
    assign room_bus[r].manual = manual_reg[r];
    tsl_room u_room (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .rb(room_bus[r])
    );
  end

  // room outputs to pins
  assign o_dim_room_a = room_bus[0].dim;
  assign o_dim_room_b = room_bus[1].dim;
  assign o_cut_room_a = room_bus[0].cut;
  assign o_cut_room_b = room_bus[1].cut;
  assign o_cut_external_path_one = room_bus[0].ext_cut;
  assign o_cut_external_path_two = room_bus[1].ext_cut;
  assign o_room_a_signal_one_lamp = room_bus[0].sig_lamp[0];
  assign o_room_a_signal_two_lamp = room_bus[0].sig_lamp[1];
  assign o_room_b_signal_one_lamp = room_bus[1].sig_lamp[0];
  assign o_room_b_signal_two_lamp = room_bus[1].sig_lamp[1];
  assign o_room_a_warning_lamp = room_bus[0].warn_lamp;
  assign o_room_b_warning_lamp = room_bus[1].warn_lamp;
  assign o_room_a_talk_lamp = room_bus[0].talk_lamp;
  assign o_room_b_talk_lamp = room_bus[1].talk_lamp;

  // control register write
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (i_wr && i_addr == CTRL_OFS) begin
      ctrl_reg <= i_wdata;
    end
  end

  // manual warning requests: key pulse or written one toggles
  assign warn_wr_toggle = (i_wr && i_addr == WARN_OFS) ?
    i_wdata[ROOMS-1:0] : WARN_RST;
  assign manual_next = manual_reg
    ^ (warn_wr_toggle | i_warning_lamp_manual_key);
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      manual_reg <= WARN_RST;
    end else begin
      manual_reg <= manual_next;
    end
  end
  assign o_warning_key_lamp = manual_reg;

  // broadcast mode from key bit or the selected general input
  assign gpi_select = ctrl_reg[CTRL_SEL_LSB +: 2];
  assign broadcast_mode_next = ctrl_reg[CTRL_KEY_BIT]
    | gpi_sync[gpi_select];
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      broadcast_mode_reg <= 1'b0;
    end else begin
      broadcast_mode_reg <= broadcast_mode_next;
    end
  end
  assign o_broadcast_mode = broadcast_mode_reg;

  // hazardous functions refused while broadcasting
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      solo_grant_reg <= 1'b0;
      masters_grant_reg <= 1'b0;
    end else begin
      solo_grant_reg <= i_solo_in_place_req & ~broadcast_mode_reg;
      masters_grant_reg <= i_talk_to_masters_req
        & ~broadcast_mode_reg;
    end
  end
  assign o_solo_in_place_grant = solo_grant_reg;
  assign o_talk_to_masters_grant = masters_grant_reg;

  // control room and prelisten dim on desk, console or studio talk, or producer talk in the control room
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      dim_monitor_reg <= 1'b0;
    end else begin
      dim_monitor_reg <= any_desk_talk
        | (i_producer_talk & i_producer_in_control_room);
    end
  end
  assign o_dim_control_room = dim_monitor_reg;
  assign o_dim_prelisten_feed = dim_monitor_reg;

  // status word and read mux, unmapped reads return zero
  assign status_word = {room_bus[1].warn_lamp, room_bus[0].warn_lamp,
    room_bus[1].ext_cut, room_bus[0].ext_cut, room_bus[1].cut,
    room_bus[0].cut, dim_monitor_reg, broadcast_mode_reg};
  always_comb begin
    rdata_next = 8'h00;
    if (i_rd) begin
      case (i_addr)
        CTRL_OFS: rdata_next = ctrl_reg;
        WARN_OFS: rdata_next = {6'h00, manual_reg};
        STAT_OFS: rdata_next = status_word;
        GPI_OFS: rdata_next = {4'h0, gpi_sync};
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign o_rdata = rdata_reg;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_dim_monitors: assert property (
    i_producer_talk && i_producer_in_control_room |=>
      o_dim_control_room && o_dim_prelisten_feed)
    else $error("producer talk did not dim monitors");
  chk_dim_release: assert property (
    (!any_desk_talk && !i_producer_talk) [*2] |-> !o_dim_control_room)
    else $error("monitor dim held without talk");
  chk_broadcast_key: assert property (
    ctrl_reg[CTRL_KEY_BIT] |=> o_broadcast_mode)
    else $error("broadcast key ignored");
  chk_manual_toggle: assert property (
    i_wr && i_addr == WARN_OFS && i_wdata[0]
      && !i_warning_lamp_manual_key[0]
      |=> o_warning_key_lamp[0] != $past(o_warning_key_lamp[0]))
    else $error("manual warning request did not toggle");
  chk_hazard_block: assert property (
    o_solo_in_place_grant || o_talk_to_masters_grant
      |-> !$past(o_broadcast_mode))
    else $error("hazardous function granted in broadcast");
  chk_studio_talk: assert property (
    i_studio_talk_key |=> o_room_a_talk_lamp && o_room_b_talk_lamp)
    else $error("studio talk missed a room");
  chk_pin_latency: assert property (
    $rose(i_room_a_signal_one_in) ##0 i_room_a_signal_one_in [*4]
      |-> o_room_a_signal_one_lamp)
    else $error("signal input not shown within three edges");
  chk_reset_clear: assert property (
    disable iff (1'b0) i_rst |=> !o_broadcast_mode && !o_cut_room_a
      && !o_cut_room_b && o_warning_key_lamp == 2'h0
      && !o_dim_control_room)
    else $error("outputs not cleared by reset");
  chk_read_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read cycle");

  chk_desk_dim: assert property (
    i_desk_talk |=> o_dim_control_room && o_dim_prelisten_feed)
    else $error("desk talk did not dim monitors");

  chk_room_b_cut: assert property (
    i_fader_start_room_b |=> o_cut_room_b && o_room_b_warning_lamp)
    else $error("fader start did not cut room b");

  chk_ext_two: assert property (
    i_fader_start_room_b && i_return_path_two_in_room
      |=> o_cut_external_path_two)
    else $error("external path two not cut");

  chk_broadcast_cut: assert property (
    o_broadcast_mode && ctrl_reg[CTRL_ASSIGN_LSB]
      |=> o_cut_room_a && o_room_a_warning_lamp)
    else $error("broadcast state did not cut room a");

  chk_return_lamp: assert property (
    i_return_one_talk_to_control_room |=> o_room_a_talk_lamp)
    else $error("return talk did not light room a lamp");

  chk_gpi_broadcast: assert property (
    gpi_sync[gpi_select] |=> o_broadcast_mode)
    else $error("selected input did not enter broadcast");

  chk_broadcast_cause: assert property (
    o_broadcast_mode
      |-> $past(ctrl_reg[CTRL_KEY_BIT] || gpi_sync[gpi_select]))
    else $error("broadcast mode without cause");

  chk_key_toggle: assert property (
    i_warning_lamp_manual_key[1] && !i_wr
      |=> o_warning_key_lamp[1] != $past(o_warning_key_lamp[1]))
    else $error("warning key did not toggle request");

  chk_manual_hold: assert property (
    !i_warning_lamp_manual_key[0] && !i_wr
      |=> $stable(o_warning_key_lamp[0]))
    else $error("manual request changed without key");

  chk_solo_free: assert property (
    i_solo_in_place_req && !o_broadcast_mode |=> o_solo_in_place_grant)
    else $error("solo refused outside broadcast");

  chk_masters_free: assert property (
    i_talk_to_masters_req && !o_broadcast_mode
      |=> o_talk_to_masters_grant)
    else $error("talk to masters refused outside broadcast");

  cov_broadcast: cover property ($rose(o_broadcast_mode));
  cov_ext_cut: cover property (o_cut_external_path_one && o_dim_room_a);
  cov_manual_warn: cover property (
    o_room_b_warning_lamp && !o_cut_room_b);
  cov_hazard_refused: cover property (
    o_broadcast_mode && i_solo_in_place_req);
  cov_key_toggle: cover property ($changed(o_warning_key_lamp));
endmodule

// ===== verilog/tsl_pkg.sv
// constants shared by the talkback signaling logic
package tsl_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int GPI_W = 4;
  localparam int SIG_IN_W = 4;
  localparam int SYNC_W = GPI_W + SIG_IN_W;
  localparam int ROOMS = 2;
  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] WARN_OFS = 4'h4;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h8;
  localparam logic [ADDR_W-1:0] GPI_OFS = 4'hC;
  // control register fields
  localparam int CTRL_KEY_BIT = 0;
  localparam int CTRL_ASSIGN_LSB = 1;
  localparam int CTRL_SEL_LSB = 4;
  // values after reset
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [ROOMS-1:0] WARN_RST = 2'h0;
  localparam logic [SYNC_W-1:0] SYNC_RST = 8'h00;
  // edges from a pin change to the lamp that shows it
  localparam int PIN_TO_LAMP_CYC = 3;
endpackage

// ===== verilog/tsl_room_if.sv
// signals between the console core and one room's signaling logic
`timescale 1ns/10ps
interface tsl_room_if;
  logic ret_talk;
  logic ret_in_studio;
  logic fader_start;
  logic onair;
  logic console_talk;
  logic manual;
  logic [1:0] sig_out;
  logic [1:0] sig_in;
  logic dim;
  logic cut;
  logic ext_cut;
  logic warn_lamp;
  logic talk_lamp;
  logic [1:0] sig_lamp;
  modport ctl(output ret_talk, ret_in_studio, fader_start, onair,
    console_talk, manual, sig_out, sig_in,
    input dim, cut, ext_cut, warn_lamp, talk_lamp, sig_lamp);
  modport room(input ret_talk, ret_in_studio, fader_start, onair,
    console_talk, manual, sig_out, sig_in,
    output dim, cut, ext_cut, warn_lamp, talk_lamp, sig_lamp);
endinterface

// ===== verilog/tsl_sync.sv
// two flip-flop synchroniser for optocoupler inputs
`timescale 1ns/10ps
module tsl_sync
  import tsl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [SYNC_W-1:0] i_async,
  output logic [SYNC_W-1:0] o_sync
);
  logic [SYNC_W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      meta_reg <= SYNC_RST;
      o_sync <= SYNC_RST;
    end else begin
      meta_reg <= i_async;
      o_sync <= meta_reg;
    end
  end
endmodule

// ===== verilog/tsl_room.sv
// dim, cut and lamp logic for one room and its return path
`timescale 1ns/10ps
module tsl_room
  import tsl_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  tsl_room_if.room rb
);
  logic cut_next;

  // room cut from fader start or broadcast state
  assign cut_next = rb.fader_start | rb.onair;

  // all room outputs registered, cleared on reset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rb.dim <= 1'b0;
      rb.cut <= 1'b0;
      rb.ext_cut <= 1'b0;
      rb.warn_lamp <= 1'b0;
      rb.talk_lamp <= 1'b0;
      rb.sig_lamp <= 2'h0;
    end else begin
      rb.dim <= rb.ret_talk & rb.ret_in_studio;
      rb.cut <= cut_next;
      rb.ext_cut <= cut_next & rb.ret_in_studio;
      rb.warn_lamp <= cut_next | rb.manual;
      rb.talk_lamp <= rb.console_talk | rb.ret_talk;
      rb.sig_lamp <= rb.sig_out | rb.sig_in;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  chk_room_dim: assert property (
    rb.ret_talk && rb.ret_in_studio |=> rb.dim)
    else $error("room dim missing after return talk");
  chk_ext_follows: assert property (
    rb.ext_cut |-> rb.cut && $past(rb.ret_in_studio))
    else $error("external cut without room cut");
  chk_warn_on_cut: assert property (
    rb.cut |-> rb.warn_lamp)
    else $error("room cut without warning lamp");
  chk_cut_cause: assert property (
    $rose(rb.cut) |-> $past(rb.fader_start || rb.onair))
    else $error("room cut without cause");
  chk_sig_lamp: assert property (
    $past(rb.sig_out[0] || rb.sig_in[0]) == rb.sig_lamp[0]
      || $past(i_rst))
    else $error("signal one lamp wrong");
endmodule

// ===== verification/tsl_panel_model.sv
// behavioural model of the studio panels and general input pins
`timescale 1ns/10ps
module tsl_panel_model (
  input wire logic i_slow,
  input wire logic [3:0] i_sig_req,
  input wire logic [3:0] i_gpi_req,
  output logic [3:0] o_sig_in,
  output logic [3:0] o_gpi
);
  // optocoupler pins settle before reset ends
  initial begin
    o_sig_in = 4'h0;
    o_gpi = 4'h0;
  end
  // pins move at times unrelated to the clock, fast or slow
  always @(i_sig_req) begin
    o_sig_in <= #(i_slow ? 237 : 37) i_sig_req;
  end
  always @(i_gpi_req) begin
    o_gpi <= #(i_slow ? 263 : 63) i_gpi_req;
  end
endmodule

// ===== verification/talkback_signaling_logic_bench.sv
// self-checking bench for the talkback signaling logic
`timescale 1ns/10ps
module talkback_signaling_logic_bench;
  import tsl_pkg::*;
  logic clk;
  logic rst;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata;
  logic [26:0] stim;
  logic [ROOMS-1:0] key;
  logic [3:0] sig_pin;
  logic [3:0] gpi_pin;
  logic [20:0] act;
  logic [DATA_W-1:0] ctrl;
  logic [ROOMS-1:0] warn;
  logic [7:0] lfsr;
  logic [31:0] r;
  int n_errors;
  int check_count;
  int cycles;

  tsl_panel_model u_panel (.i_slow(stim[26]), .i_sig_req(stim[19:16]),
    .i_gpi_req(stim[25:22]), .o_sig_in(sig_pin), .o_gpi(gpi_pin));

  tsl_top u_dut (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_desk_talk(stim[0]), .i_producer_talk(stim[1]),
    .i_producer_in_control_room(stim[2]), .i_studio_talk_key(stim[3]),
    .i_console_talk_to_room_a(stim[4]), .i_console_talk_to_room_b(stim[5]),
    .i_return_one_talk_to_control_room(stim[6]),
    .i_return_two_talk_to_control_room(stim[7]),
    .i_return_path_one_in_room(stim[8]), .i_return_path_two_in_room(stim[9]),
    .i_fader_start_room_a(stim[10]), .i_fader_start_room_b(stim[11]),
    .i_room_a_signal_one_out(stim[12]), .i_room_a_signal_two_out(stim[13]),
    .i_room_b_signal_one_out(stim[14]), .i_room_b_signal_two_out(stim[15]),
    .i_room_a_signal_one_in(sig_pin[0]), .i_room_a_signal_two_in(sig_pin[1]),
    .i_room_b_signal_one_in(sig_pin[2]), .i_room_b_signal_two_in(sig_pin[3]),
    .i_gpi(gpi_pin), .i_warning_lamp_manual_key(key),
    .i_solo_in_place_req(stim[20]), .i_talk_to_masters_req(stim[21]),
    .o_dim_control_room(act[20]), .o_dim_prelisten_feed(act[19]),
    .o_dim_room_a(act[18]), .o_dim_room_b(act[17]),
    .o_cut_room_a(act[16]), .o_cut_room_b(act[15]),
    .o_cut_external_path_one(act[14]), .o_cut_external_path_two(act[13]),
    .o_room_a_signal_one_lamp(act[12]), .o_room_a_signal_two_lamp(act[11]),
    .o_room_a_warning_lamp(act[10]), .o_room_a_talk_lamp(act[9]),
    .o_room_b_signal_one_lamp(act[8]), .o_room_b_signal_two_lamp(act[7]),
    .o_room_b_warning_lamp(act[6]), .o_room_b_talk_lamp(act[5]),
    .o_warning_key_lamp(act[4:3]), .o_broadcast_mode(act[2]),
    .o_solo_in_place_grant(act[1]), .o_talk_to_masters_grant(act[0]));

  // clock of 100 ns period
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // expected outputs from held inputs, control bits and manual requests
  function automatic logic [20:0] expect_out(input logic [26:0] s,
      input logic [DATA_W-1:0] c, input logic [ROOMS-1:0] w);
    logic bm, ta, tb, ca, cb, dc;
    ta = s[4] | s[3];
    tb = s[5] | s[3];
    bm = c[CTRL_KEY_BIT] | s[22 + c[CTRL_SEL_LSB +: 2]];
    ca = s[10] | (bm & c[CTRL_ASSIGN_LSB]);
    cb = s[11] | (bm & c[CTRL_ASSIGN_LSB+1]);
    dc = s[0] | (s[1] & s[2]) | ta | tb;
    return {dc, dc, s[6] & s[8], s[7] & s[9], ca, cb, ca & s[8], cb & s[9],
      s[12] | s[16], s[13] | s[17], ca | w[0], ta | s[6],
      s[14] | s[18], s[15] | s[19], cb | w[1], tb | s[7],
      w, bm, s[20] & !bm, s[21] & !bm};
  endfunction

  // expected status register
  function automatic logic [7:0] expect_stat(input logic [20:0] e);
    return {e[6], e[10], e[13], e[14], e[15], e[16], e[20], e[2]};
  endfunction

  function automatic logic [7:0] step(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read strobe for one cycle, data looked at in the cycle after only
  task automatic read_check(input logic [3:0] a, input logic [7:0] v,
      input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, v, what);
    @(posedge clk);
  endtask

  task automatic pulse_key(input logic [1:0] m);
    @(posedge clk);
    key <= m;
    @(posedge clk);
    key <= 2'h0;
    warn = warn ^ m;
  endtask

  // hold inputs long enough for synchronisers, then compare all outputs
  task automatic settle_check();
    logic [20:0] e;
    repeat (10) @(posedge clk);
    @(negedge clk);
    e = expect_out(stim, ctrl, warn);
    check(act[20:17], e[20:17], "dims");
    check(act[16:13], e[16:13], "cuts");
    check(act[12:9], e[12:9], "room a lamps");
    check(act[8:5], e[8:5], "room b lamps");
    check(act[4:2], e[4:2], "key lamps, mode");
    check(act[1:0], e[1:0], "grants");
    read_check(STAT_OFS, expect_stat(e), "status");
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(act, 21'h0, "outputs held in reset");
    @(posedge clk);
    rst <= 1'b0;
    ctrl = CTRL_RST;
    warn = WARN_RST;
    @(negedge clk);
    check(act, 21'h0, "outputs after reset");
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      end_sim();
    end
  end

  initial begin
    rst = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    stim = '0;
    key = '0;
    ctrl = CTRL_RST;
    warn = WARN_RST;
    lfsr = 8'h5E;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check(act, 21'h0, "first edge after reset");
    read_check(WARN_OFS, 8'h00, "warn after reset");
    // a level input reaches its output exactly one edge later
    @(posedge clk);
    stim[10] <= 1'b1;
    @(negedge clk);
    check(act[16], 1'b0, "cut too early");
    @(negedge clk);
    check({act[16], act[10]}, 2'h3, "cut one edge later");
    @(posedge clk);
    stim[10] <= 1'b0;
    $display("test done: latency");
    // broadcast from each input select with both rooms assigned
    stim[21:20] <= 2'h3;
    stim[9:8] <= 2'h3;
    for (int s = 0; s < 4; s++) begin
      ctrl = 8'(s << CTRL_SEL_LSB) | 8'h06;
      bus_write(CTRL_OFS, ctrl);
      stim[25:22] <= 4'(1 << s);
      settle_check();
      read_check(GPI_OFS, 8'(1 << s), "gpi read");
      stim[25:22] <= ~4'(1 << s);
      settle_check();
    end
    ctrl = 8'h03;
    bus_write(CTRL_OFS, ctrl);
    settle_check();
    $display("test done: broadcast sources");
    // manual requests by key, by register and both in one cycle
    pulse_key(2'h1);
    bus_write(WARN_OFS, 8'h02);
    warn[1] = ~warn[1];
    settle_check();
    @(posedge clk);
    key <= 2'h1;
    wr <= 1'b1;
    addr <= WARN_OFS;
    wdata <= 8'h01;
    @(posedge clk);
    key <= 2'h0;
    wr <= 1'b0;
    warn[0] = ~warn[0];
    read_check(WARN_OFS, 8'(warn), "warn toggle once");
    $display("test done: manual requests");
    // unmapped read and read-only writes
    read_check(4'h2, 8'h00, "unmapped read");
    bus_write(STAT_OFS, 8'hFF);
    bus_write(GPI_OFS, 8'hFF);
    settle_check();
    $display("test done: register map");
    // random traffic on every input
    for (int i = 0; i < 60; i++) begin
      for (int k = 0; k < 4; k++) begin
        lfsr = step(lfsr);
        r[8*k +: 8] = lfsr;
      end
      stim <= r[26:0];
      ctrl = {2'h0, r[31:30], 1'b0, r[29:28], r[27] & r[28]};
      bus_write(CTRL_OFS, ctrl);
      pulse_key(r[31:30]);
      settle_check();
    end
    $display("test done: random");
    // second reset with everything active
    stim <= '1;
    settle_check();
    do_reset();
    settle_check();
    $display("test done: reset in mid-run");
    end_sim();
  end
endmodule
